// [verilog/gsh_pkg.sv]
/*
 * gsh_pkg: shared constants and types for the general-purpose strobe host port.
 * Assumes both ends run on one shared sys_clk at 40 MHz and meet in gsh_link_if.
 */
package gsh_pkg;
    localparam int unsigned ADDR_W       = 17;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned MEM_WORDS    = 64;
    localparam int unsigned MEM_AW       = 6;
    // link clock divider half period in sys_clk cycles (host makes the clock)
    localparam logic [3:0]  LCLK_HALF    = 4'h4;
    // refresh contention: busy window length in link clocks, and last count of an 11-link-clock repeat period
    localparam logic [3:0]  REFRESH_LEN  = 4'h3;
    localparam logic [3:0]  REFRESH_PER  = 4'hA;
    // strap decode values
    localparam logic [2:0]  BUS_SEL_GEN  = 3'h7;
    localparam logic        BS_GEN       = 1'b1;
    localparam logic        ENDIAN_BIG   = 1'b1;
    // controller register offsets
    localparam logic [3:0]  REG_ADDR     = 4'h0;
    localparam logic [3:0]  REG_WDATA    = 4'h1;
    localparam logic [3:0]  REG_CMD      = 4'h2;
    localparam logic [3:0]  REG_STATUS   = 4'h3;
    localparam logic [3:0]  REG_RDATA    = 4'h4;
    // command register fields
    localparam int unsigned CMD_GO       = 0;
    localparam int unsigned CMD_WRITE    = 1;
    localparam int unsigned CMD_BYTE     = 2;

    typedef enum logic [4:0] {
        GSH_H_IDLE  = 5'b00001,
        GSH_H_ADDR  = 5'b00010,
        GSH_H_SEL   = 5'b00100,
        GSH_H_STROB = 5'b01000,
        GSH_H_END   = 5'b10000
    } gsh_host_state_t;

    typedef enum logic [2:0] {
        GSH_D_IDLE  = 3'b001,
        GSH_D_WAIT  = 3'b010,
        GSH_D_DONE  = 3'b100
    } gsh_dev_state_t;
endpackage : gsh_pkg

// [verilog/gsh_link_if.sv]
/*
 * gsh_link_if: host port pins between the host end and the display device end.
 * The interface resolves the shared data bus from the two enables, device enable first.
 */
`timescale 1ns/100ps
`default_nettype none
interface gsh_link_if;
    logic        host_transfer_clock;
    logic [16:0] host_addr_in;
    logic [15:0] host_data_host;
    logic        host_data_host_oe;
    logic [15:0] host_data_dev;
    logic        host_data_dev_oe;
    logic [15:0] host_data_io;
    logic        host_display_select_n;
    logic        high_byte_enable_n;
    logic        low_write_strobe_n;
    logic        read_strobe_n;
    logic        wait_n;
    logic        bus_status_strap_n;
    logic        read_write_n;

    // resolved bus level, pulled high when nobody drives
    assign host_data_io = host_data_dev_oe ? host_data_dev :
                          host_data_host_oe ? host_data_host : 16'hFFFF;

    modport host (
        output host_transfer_clock, host_addr_in, host_data_host, host_data_host_oe,
        output host_display_select_n, high_byte_enable_n, low_write_strobe_n,
        output read_strobe_n, bus_status_strap_n, read_write_n,
        input  host_data_io, wait_n
    );
    modport device (
        input  host_transfer_clock, host_addr_in, host_data_io, host_display_select_n,
        input  high_byte_enable_n, low_write_strobe_n, read_strobe_n,
        input  bus_status_strap_n, read_write_n,
        output host_data_dev, host_data_dev_oe, wait_n
    );
endinterface : gsh_link_if
`default_nettype wire

// [verilog/gsh_device.sv]
/*
 * gsh_device: display controller end of the strobe host port, with a small
 * register/memory array and a refresh arbiter that forces wait states.
 * Assumes the host end keeps its strobe ordering; straps are plain pins that
 * settle while reset is high and pass two flip-flops like the strobe and select pins.
 */
`timescale 1ns/100ps
`default_nettype none
module gsh_device (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    gsh_link_if.device  link,
    input  wire logic   endian_strap,
    input  wire logic   bus_select_strap_0,
    input  wire logic   bus_select_strap_1,
    input  wire logic   bus_select_strap_2,
    output logic        mode_ok,
    output logic        big_endian,
    output logic        host_busy
);
    typedef struct packed {
        logic [1:0]            clk_s;
        logic                  clk_last;
        logic [1:0]            cs_s;
        logic [1:0]            rd_s;
        logic [1:0]            we_s;
        logic [1:0]            hb_s;
        logic [1:0]            bs_s;
        logic [3:0]            strap_a;
        logic [3:0]            strap_b;
        logic [16:0]           addr_q;
        logic [15:0]           din_q;
        logic                  rst_last;
        logic                  mode_ok;
        logic                  big_endian;
        gsh_pkg::gsh_dev_state_t st;
        logic                  wait_n;
        logic [15:0]           dout;
        logic                  dout_oe;
        logic [3:0]            ref_cnt;
        logic                  refresh;
    } gsh_dev_t;

    // registered state and the value it takes at the next edge
    gsh_dev_t r;
    gsh_dev_t next_r;
    // word store behind the port, reached by address bits above the byte bit
    logic [15:0] mem [gsh_pkg::MEM_WORDS];
    // decoded views of the synchronised pins
    logic        lclk_rise;
    logic        sel;
    logic        rd;
    logic        wr;
    logic [5:0]  idx;
    logic [15:0] rword;
    logic        do_write;

    // a link clock edge is seen in the cycle the second flip-flop first shows it;
    // the mode gate keeps a wrongly strapped device off the bus entirely
    assign lclk_rise = r.clk_s[1] & ~r.clk_last;
    assign sel       = ~r.cs_s[1] & r.mode_ok;
    assign rd        = sel & ~r.rd_s[1];
    assign wr        = sel & ~r.we_s[1];
    assign idx       = r.addr_q[gsh_pkg::MEM_AW:1];
    // a write lands on the edge that releases wait, so accepted means stored
    assign do_write  = (r.st == gsh_pkg::GSH_D_WAIT) && lclk_rise && !r.refresh && wr;

    // read word with byte lanes swapped in big endian mode
    always_comb begin
        rword = mem[idx];
        if (r.big_endian) begin
            rword = {rword[7:0], rword[15:8]};
        end
    end

    // next state: pin synchronisers, strap capture, refresh and cycle sequencer
    always_comb begin
        next_r          = r;
        next_r.clk_s    = {r.clk_s[0], link.host_transfer_clock};
        next_r.clk_last = r.clk_s[1];
        next_r.cs_s     = {r.cs_s[0], link.host_display_select_n};
        next_r.rd_s     = {r.rd_s[0], link.read_strobe_n};
        next_r.we_s     = {r.we_s[0], link.low_write_strobe_n};
        next_r.hb_s     = {r.hb_s[0], link.high_byte_enable_n};
        next_r.bs_s     = {r.bs_s[0], link.bus_status_strap_n};
        // straps take the same two-stage path as the strobe and select pins
        next_r.strap_a  = {endian_strap, bus_select_strap_2, bus_select_strap_1,
                           bus_select_strap_0};
        next_r.strap_b  = r.strap_a;
        next_r.addr_q   = link.host_addr_in;
        next_r.din_q    = link.host_data_io;
        next_r.rst_last = 1'b0;
        // straps caught at the first clock after reset release
        if (r.rst_last) begin
            next_r.mode_ok    = (r.strap_b[2:0] == gsh_pkg::BUS_SEL_GEN) &&
                                (r.bs_s[1] == gsh_pkg::BS_GEN);
            next_r.big_endian = (r.strap_b[3] == gsh_pkg::ENDIAN_BIG);
        end
        // refresh window repeats on link clock edges
        if (lclk_rise) begin
            next_r.ref_cnt = (r.ref_cnt == gsh_pkg::REFRESH_PER) ? 4'h0 : r.ref_cnt + 4'h1;
            next_r.refresh = (r.ref_cnt < gsh_pkg::REFRESH_LEN);
        end
        // cycle sequencer: wait low until arbitration allows the access
        case (r.st)
            gsh_pkg::GSH_D_IDLE: begin
                next_r.wait_n = 1'b1;
                // a synchronised strobe opens a cycle with wait already low
                if (rd || wr) begin
                    next_r.st     = gsh_pkg::GSH_D_WAIT;
                    next_r.wait_n = 1'b0;
                end
            end
            gsh_pkg::GSH_D_WAIT: begin
                if (lclk_rise && !r.refresh) begin
                    next_r.st     = gsh_pkg::GSH_D_DONE;
                    next_r.wait_n = 1'b1;
                    // read data and wait release land together, never stale
                    if (rd) begin
                        next_r.dout = r.hb_s[1] ? {8'h00, rword[7:0]} : rword;
                    end
                end
            end
            gsh_pkg::GSH_D_DONE: begin
                // hold until the strobe drops so one strobe makes one access
                if (!rd && !wr) begin
                    next_r.st = gsh_pkg::GSH_D_IDLE;
                end
            end
            default: begin
                next_r.st = gsh_pkg::GSH_D_IDLE;
            end
        endcase
        // registered enable; the pad gate below cuts it at strobe release
        next_r.dout_oe = rd && (r.st != gsh_pkg::GSH_D_IDLE);
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r          <= '0;
            r.rst_last <= 1'b1;
            r.st       <= gsh_pkg::GSH_D_IDLE;
            r.wait_n   <= 1'b1;
            r.clk_s    <= 2'b00;
            r.cs_s     <= 2'b11;
            r.rd_s     <= 2'b11;
            r.we_s     <= 2'b11;
            r.hb_s     <= 2'b11;
            // strap synchronisers keep running so they are settled at release
            r.bs_s     <= next_r.bs_s;
            r.strap_a  <= next_r.strap_a;
            r.strap_b  <= next_r.strap_b;
        end else begin
            r <= next_r;
        end
    end

    // storage array, low lane always, high lane when enabled
    always_ff @(posedge sys_clk) begin
        if (do_write) begin
            // big endian crosses the lanes between pin and array
            if (r.big_endian) begin
                mem[idx][15:8] <= r.din_q[7:0];
                if (!r.hb_s[1]) begin
                    mem[idx][7:0] <= r.din_q[15:8];
                end
            end else begin
                mem[idx][7:0] <= r.din_q[7:0];
                if (!r.hb_s[1]) begin
                    mem[idx][15:8] <= r.din_q[15:8];
                end
            end
        end
    end

    // pins and status
    assign link.wait_n           = r.wait_n;
    assign link.host_data_dev    = r.dout;
    // the registered enable lags the raw pins by three cycles; cutting it
    // with the raw select and read strobe turns the pad off the moment the host
    // lets go, so the two ends never fight over the data lines
    assign link.host_data_dev_oe = r.dout_oe && !link.host_display_select_n &&
                                   !link.read_strobe_n;
    assign mode_ok               = r.mode_ok;
    assign big_endian            = r.big_endian;
    assign host_busy             = (r.st != gsh_pkg::GSH_D_IDLE);
endmodule : gsh_device
`default_nettype wire

// [verilog/gsh_host.sv]
/*
 * gsh_host: host bus end; makes the transfer clock, sequences address,
 * select and strobes, stalls on wait. Software reaches it by a plain port.
 * Assumes the device end answers with an active-low wait.
 */
`timescale 1ns/100ps
`default_nettype none
module gsh_host (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    gsh_link_if.host         link,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata
);
    typedef struct packed {
        logic [3:0]            div;
        logic                  lclk;
        logic [16:0]           addr;
        logic [15:0]           wdata;
        logic [15:0]           rdata;
        logic                  write;
        logic                  byte8;
        logic                  done;
        gsh_pkg::gsh_host_state_t st;
        logic [1:0]            wait_s;
        logic [31:0]           rdo;
    } gsh_host_s_t;

    gsh_host_s_t r;
    gsh_host_s_t next_r;
    logic        fall;
    logic        busy;

    assign fall = r.lclk && (r.div == gsh_pkg::LCLK_HALF - 4'h1);
    assign busy = (r.st != gsh_pkg::GSH_H_IDLE);

    always_comb begin
        next_r        = r;
        next_r.wait_s = {r.wait_s[0], link.wait_n};
        // transfer clock divider
        if (r.div == gsh_pkg::LCLK_HALF - 4'h1) begin
            next_r.div  = 4'h0;
            next_r.lclk = ~r.lclk;
        end else begin
            next_r.div = r.div + 4'h1;
        end
        // software register port
        next_r.rdo = 32'h0000_0000;
        if (reg_wr && !busy) begin
            case (reg_addr)
                gsh_pkg::REG_ADDR:  next_r.addr  = reg_wdata[16:0];
                gsh_pkg::REG_WDATA: next_r.wdata = reg_wdata[15:0];
                gsh_pkg::REG_CMD: begin
                    if (reg_wdata[gsh_pkg::CMD_GO]) begin
                        next_r.write = reg_wdata[gsh_pkg::CMD_WRITE];
                        next_r.byte8 = reg_wdata[gsh_pkg::CMD_BYTE];
                        next_r.done  = 1'b0;
                        next_r.st    = gsh_pkg::GSH_H_ADDR;
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                gsh_pkg::REG_ADDR:   next_r.rdo = {15'h0000, r.addr};
                gsh_pkg::REG_WDATA:  next_r.rdo = {16'h0000, r.wdata};
                gsh_pkg::REG_STATUS: next_r.rdo = {30'h0000_0000, r.done, busy};
                gsh_pkg::REG_RDATA:  next_r.rdo = {16'h0000, r.rdata};
                default:             next_r.rdo = 32'h0000_0000;
            endcase
        end
        // bus cycle, each step on a falling transfer clock edge
        case (r.st)
            gsh_pkg::GSH_H_IDLE: ;
            gsh_pkg::GSH_H_ADDR:  if (fall) next_r.st = gsh_pkg::GSH_H_SEL;
            gsh_pkg::GSH_H_SEL:   if (fall) next_r.st = gsh_pkg::GSH_H_STROB;
            gsh_pkg::GSH_H_STROB: begin
                if (fall && r.wait_s[1]) begin
                    next_r.st = gsh_pkg::GSH_H_END;
                    if (!r.write) begin
                        next_r.rdata = link.host_data_io;
                    end
                end
            end
            gsh_pkg::GSH_H_END: begin
                if (fall) begin
                    next_r.st   = gsh_pkg::GSH_H_IDLE;
                    next_r.done = 1'b1;
                end
            end
            default: next_r.st = gsh_pkg::GSH_H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r        <= '0;
            r.st     <= gsh_pkg::GSH_H_IDLE;
            r.wait_s <= 2'b11;
        end else begin
            r <= next_r;
        end
    end

    // pins; strobe is asserted one link clock period after select goes low
    assign link.host_transfer_clock   = r.lclk;
    assign link.host_addr_in          = r.addr;
    assign link.host_display_select_n = !(r.st == gsh_pkg::GSH_H_SEL ||
                                          r.st == gsh_pkg::GSH_H_STROB);
    assign link.low_write_strobe_n    = !(r.st == gsh_pkg::GSH_H_STROB && r.write);
    assign link.read_strobe_n         = !(r.st == gsh_pkg::GSH_H_STROB && !r.write);
    assign link.high_byte_enable_n    = r.byte8;
    assign link.host_data_host        = r.wdata;
    assign link.host_data_host_oe     = busy && r.write;
    assign link.bus_status_strap_n    = 1'b1;
    assign link.read_write_n          = 1'b1;
    assign reg_rdata                  = r.rdo;
endmodule : gsh_host
`default_nettype wire

// [sim/gsh_props.sv]
/*
 * gsh_props: concurrent checks on the strobe host port pins between the two ends.
 * Assumes sys_clk and rst are shared by both ends and the interface signals come in plainly.
 */
`timescale 1ns/100ps
`default_nettype none
module gsh_props (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        host_transfer_clock,
    input wire logic [16:0] host_addr_in,
    input wire logic        host_display_select_n,
    input wire logic        high_byte_enable_n,
    input wire logic        low_write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic        wait_n,
    input wire logic        host_data_dev_oe,
    input wire logic        bus_status_strap_n,
    input wire logic        read_write_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // strobe and select ordering on the host side
    strobe_excl_a: assert property (!(!low_write_strobe_n && !read_strobe_n))
        else $error("both strobes low together");
    strobe_sel_a: assert property ((!low_write_strobe_n || !read_strobe_n)
        |-> !host_display_select_n) else $error("strobe low without select");
    addr_hold_a: assert property ((!host_display_select_n && $past(!host_display_select_n))
        |-> $stable({host_addr_in, high_byte_enable_n})) else $error("address moved in cycle");
    // device drive and wait behaviour, static pins and link clock
    dev_drive_a: assert property (host_data_dev_oe
        |-> (!host_display_select_n && !read_strobe_n)) else $error("device drives outside read");
    read_drive_a: assert property (($rose(wait_n) && !read_strobe_n)
        |-> host_data_dev_oe) else $error("no drive at read release");
    wait_sel_a: assert property (!wait_n |-> !host_display_select_n)
        else $error("wait low while not selected");
    wait_bound_a: assert property ($fell(wait_n) |-> ##[1:400] wait_n)
        else $error("wait held too long");
    host_stall_a: assert property (!wait_n |=> $stable({low_write_strobe_n, read_strobe_n}))
        else $error("host left cycle during wait");
    straps_high_a: assert property (bus_status_strap_n && read_write_n)
        else $error("status or direction low");
    lclk_half_a: assert property ($rose(host_transfer_clock)
        |-> host_transfer_clock[*4] ##1 !host_transfer_clock) else $error("link clock half period");
endmodule : gsh_props
`default_nettype wire

// [sim/generic_strobe_host_port_tb.sv]
/*
 * generic_strobe_host_port_tb: host end and device end joined by gsh_link_if,
 * driven through the host register port. Assumes gsh_pkg register offsets.
 */
`timescale 1ns/100ps
`default_nettype none
module generic_strobe_host_port_tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        endian_strap = 1'b0;
    logic [2:0]  bsel = 3'h7;
    logic        mode_ok;
    logic        big_endian;
    logic        host_busy;
    logic        le = 1'b1;
    int          err_total = 0;
    int          total_checks = 0;

    gsh_link_if link ();
    gsh_host gsh_host_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    gsh_device gsh_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link),
        .endian_strap(endian_strap), .bus_select_strap_0(bsel[0]),
        .bus_select_strap_1(bsel[1]), .bus_select_strap_2(bsel[2]),
        .mode_ok(mode_ok), .big_endian(big_endian), .host_busy(host_busy));
    gsh_props gsh_props_inst (.sys_clk(sys_clk), .rst(rst),
        .host_transfer_clock(link.host_transfer_clock), .host_addr_in(link.host_addr_in),
        .host_display_select_n(link.host_display_select_n),
        .high_byte_enable_n(link.high_byte_enable_n),
        .low_write_strobe_n(link.low_write_strobe_n), .read_strobe_n(link.read_strobe_n),
        .wait_n(link.wait_n), .host_data_dev_oe(link.host_data_dev_oe),
        .bus_status_strap_n(link.bus_status_strap_n), .read_write_n(link.read_write_n));

    // system clock, 25 ns
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic reset_run(input logic endian, input logic [2:0] sel);
        @(posedge sys_clk);
        rst <= 1'b1;
        endian_strap <= endian;
        bsel <= sel;
        le = !endian;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("mode_ok", {31'h0, mode_ok}, {31'h0, sel == gsh_pkg::BUS_SEL_GEN});
        check("big_endian", {31'h0, big_endian}, {31'h0, endian});
    endtask : reset_run

    // one link cycle; sneak writes ADDR while busy, keep skips the ADDR write
    task automatic xfer(input logic [16:0] a, input logic [15:0] d, input logic [2:0] cmd,
                        input bit sneak, input bit keep);
        logic [31:0] st;
        int          n;
        if (!keep) reg_write(gsh_pkg::REG_ADDR, {15'h0000, a});
        reg_write(gsh_pkg::REG_WDATA, {16'h0000, d});
        reg_write(gsh_pkg::REG_CMD, {29'h0, cmd});
        if (sneak) reg_write(gsh_pkg::REG_ADDR, 32'h0000_0040);
        n = 0;
        while (link.low_write_strobe_n !== 1'b0 && link.read_strobe_n !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("addr", {15'h0, link.host_addr_in}, {15'h0, a});
        check("bhe", {31'h0, link.high_byte_enable_n}, {31'h0, cmd[2]});
        if (cmd[1] && le) check("wire", {16'h0, link.host_data_io & (cmd[2] ? 16'h00FF : 16'hFFFF)}, {16'h0, d});
        repeat (3) @(posedge sys_clk);
        #1;
        check("busy", {31'h0, host_busy}, 32'h0000_0001);
        n = 0;
        do begin
            reg_read(gsh_pkg::REG_STATUS, st);
            n++;
        end while (st[0] !== 1'b0 && n < 300);
        check("status", {30'h0, st[1:0]}, 32'h0000_0002);
    endtask : xfer

    task automatic rdback(input logic [16:0] a, input logic [15:0] exp, input bit keep);
        logic [31:0] v;
        xfer(a, 16'h0000, 3'h1, 1'b0, keep);
        reg_read(gsh_pkg::REG_RDATA, v);
        check("rdata", {16'h0, v[15:0]}, {16'h0, exp});
    endtask : rdback

    // distinct words at distinct addresses, then an unmapped register write
    task automatic t_words;
        logic [31:0] v;
        for (int k = 0; k < 4; k++) xfer(17'(k * 2), 16'hA5C3 ^ 16'(k * 16'h1357), 3'h3, 1'b0, 1'b0);
        reg_write(4'hF, 32'hFFFF_FFFF);
        reg_read(gsh_pkg::REG_ADDR, v);
        check("addr_reg", v, 32'h0000_0006);
        reg_read(gsh_pkg::REG_WDATA, v);
        check("wdata_reg", v, {16'h0, 16'hA5C3 ^ 16'(3 * 16'h1357)});
        for (int k = 0; k < 4; k++) rdback(17'(k * 2), 16'hA5C3 ^ 16'(k * 16'h1357), 1'b0);
    endtask : t_words

    // byte write touches only the low lane
    task automatic t_byte;
        xfer(17'h0_0010, 16'h1234, 3'h3, 1'b0, 1'b0);
        xfer(17'h0_0010, 16'h00AB, 3'h7, 1'b0, 1'b0);
        rdback(17'h0_0010, 16'h12AB, 1'b0);
    endtask : t_byte

    // an ADDR write during a busy cycle is dropped
    task automatic t_refuse;
        xfer(17'h0_0040, 16'hDEAD, 3'h3, 1'b0, 1'b0);
        xfer(17'h0_0022, 16'hBEEF, 3'h3, 1'b1, 1'b0);
        rdback(17'h0_0022, 16'hBEEF, 1'b1);
    endtask : t_refuse

    // a word stored little endian reads swapped once big endian is strapped
    task automatic t_endian;
        xfer(17'h0_0008, 16'h5A01, 3'h3, 1'b0, 1'b0);
        reset_run(1'b1, 3'h7);
        rdback(17'h0_0008, 16'h015A, 1'b0);
        xfer(17'h0_0006, 16'h5A01, 3'h3, 1'b0, 1'b0);
        rdback(17'h0_0006, 16'h5A01, 1'b0);
    endtask : t_endian

    // with the straps off this mode the device ignores the port
    task automatic t_mode;
        logic [31:0] v;
        int          n;
        reset_run(1'b1, 3'h3);
        reg_write(gsh_pkg::REG_CMD, 32'h0000_0001);
        n = 0;
        while (link.read_strobe_n !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        repeat (4) @(posedge sys_clk);
        #1;
        check("ignored", {30'h0, link.read_strobe_n, host_busy}, 32'h0000_0000);
        repeat (30) @(posedge sys_clk);
        reg_read(gsh_pkg::REG_RDATA, v);
        check("float", v, 32'h0000_FFFF);
    endtask : t_mode

    // main sequence
    initial begin
        reset_run(1'b0, 3'h7);
        t_words;
        t_byte;
        t_refuse;
        t_endian;
        t_mode;
        close_out;
    end

    // watchdog against a hung cycle
    initial begin
        #1000000;
        err_total++;
        close_out;
    end
endmodule : generic_strobe_host_port_tb
`default_nettype wire
